// [rtl/ebs_pkg.sv]
package ebs_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int INT_CLK_MHZ  = 5;
  localparam int INT_DIV      = CLK_MHZ / INT_CLK_MHZ;
  localparam int CONV_NS_BIT  = 600;
  localparam int CONV_CYC     = (CONV_NS_BIT * CLK_MHZ + 999) / 1000;
  localparam int SAR_TICKS    = 2;
  localparam int TOS_NS       = 12400;
  localparam int TOS_CYC      = TOS_NS * CLK_MHZ / 1000;
  localparam int TOR_NS       = 51000;
  localparam int TOR_CYC      = TOR_NS * CLK_MHZ / 1000;
  localparam int CNT_W        = 20;

  // ----------------------------------------
  // Software register map and fields
  // ----------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_CFG    = 8'h04;
  localparam logic [7:0]  REG_LIM    = 8'h08;
  localparam logic [7:0]  REG_STAT   = 8'h0C;
  localparam logic [7:0]  REG_TEMP   = 8'h10;
  localparam int          CTRL_BISS  = 0;
  localparam int          CTRL_VAR   = 1;
  localparam int          CFG_ST     = 0;
  localparam int          CFG_MT     = 8;
  localparam int          CFG_IP     = 16;
  localparam int          LIM_LO     = 0;
  localparam int          LIM_HI     = 8;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] CFG_RST    = 32'h0000_0C0D;
  localparam logic [31:0] LIM_RST    = 32'h0000_C20E;

  // ----------------------------------------
  // Temperature codes, CRC generators
  // ----------------------------------------
  localparam logic [7:0]  TEMP_ZERO  = 8'h40;
  localparam logic [7:0]  WARN_LO_A  = 8'h13;
  localparam logic [7:0]  WARN_HI_A  = 8'hA9;
  localparam logic [7:0]  WARN_LO_B  = 8'h2C;
  localparam logic [7:0]  WARN_HI_B  = 8'hBD;
  localparam logic [6:0]  CRC6_POLY  = 7'h43;
  localparam logic [4:0]  CRC4_POLY  = 5'h13;

  // ----------------------------------------
  // Register-mode, CRC and SSI frame lengths
  // ----------------------------------------
  localparam logic [4:0]  RX_BITS    = 5'd16;
  localparam logic [4:0]  WR_BITS    = 5'd13;
  localparam logic [6:0]  RD_BITS    = 7'd13;
  localparam logic [6:0]  CRC6_BITS  = 7'd6;
  localparam logic [6:0]  SSI_EXTRA  = 7'd12;

  typedef enum logic [2:0] {
    EBS_IDLE, EBS_START, EBS_SENSE, EBS_SHIFT,
    EBS_REG_RX, EBS_REG_RD, EBS_REG_WR, EBS_TAIL
  } ebs_state_e;
endpackage : ebs_pkg

// [rtl/ebs_crc_ser.sv]
`timescale 1ns/1ps
module ebs_crc_ser #(
  parameter int         W    = 6,
  parameter logic [6:0] POLY = ebs_pkg::CRC6_POLY
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_clr,
  input  wire logic         i_en,
  input  wire logic         i_bit,
  output logic [W-1:0]      o_crc
);
  import ebs_pkg::*;

  initial begin
    if (W < 2 || W > 6) $error("ebs_crc_ser: W out of range");
  end

  typedef struct packed {
    logic [W-1:0] crc;
  } ebs_crc_s;

  ebs_crc_s q;
  ebs_crc_s n;
  logic     fb;

  // Zero start, message shifted MSB first; zero tail is implicit
  always_comb begin
    n  = q;
    fb = i_bit ^ q.crc[W-1];
    if (i_clr) begin
      n.crc = '0;
    end else if (i_en) begin
      n.crc = {q.crc[W-2:0], 1'b0} ^ (fb ? POLY[W-1:0] : '0);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign o_crc = q.crc;
endmodule : ebs_crc_ser

// [rtl/ebs_slave.sv]
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module ebs_slave #(
  parameter logic [2:0]  SLAVE_ID   = 3'b000,
  parameter int          REG_DEPTH  = 16,
  parameter int          TOR_CYCLES = ebs_pkg::TOR_CYC,
  parameter int          NVM_RD_CYC = 104000,
  parameter int          NVM_WR_CYC = 50000
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ma,
  output logic             o_slo,
  input  wire logic [23:0] i_st_pos,
  input  wire logic [23:0] i_mt_pos,
  input  wire logic [7:0]  i_temp,
  input  wire logic        i_led_over,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_temp_alarm
);
  import ebs_pkg::*;

  localparam int IW = $clog2(REG_DEPTH);

  initial begin
    if (REG_DEPTH < 2 || REG_DEPTH > 128 || (1 << IW) != REG_DEPTH)
      $error("ebs_slave: REG_DEPTH must be a power of two up to 128");
    if (TOR_CYCLES < TOS_CYC || TOR_CYCLES > 65535)
      $error("ebs_slave: TOR_CYCLES out of range");
    if (NVM_RD_CYC < 1 || NVM_RD_CYC >= (1 << CNT_W) || NVM_WR_CYC < 1 ||
        NVM_WR_CYC >= (1 << CNT_W))
      $error("ebs_slave: NVM counts out of range");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic             ma1;
    logic             ma2;
    logic             mad;
    ebs_state_e       st;
    logic             slo;
    logic             ack;
    logic             regm;
    logic             phcrc;
    logic             got;
    logic [63:0]      sh;
    logic [6:0]       left;
    logic [5:0]       div;
    logic [15:0]      conv;
    logic [15:0]      tmr;
    logic [15:0]      hi;
    logic [15:0]      per;
    logic [4:0]       bitn;
    logic [15:0]      rx;
    logic [7:0]       addr8;
    logic             hit;
    logic [CNT_W-1:0] wait_c;
    logic [CNT_W-1:0] nvm;
    logic [7:0]       nva;
    logic [7:0]       nvd;
    logic [31:0]      ctrl;
    logic [31:0]      cfg;
    logic [31:0]      lim;
    logic [31:0]      rdata;
    logic             talarm;
  } ebs_core_s;

  ebs_core_s   q;
  ebs_core_s   n;
  logic [7:0]  mem [2*REG_DEPTH];
  logic        we;
  logic [IW:0] widx;
  logic [7:0]  wd;
  logic        crc_clr;
  logic        crc_en;
  logic [5:0]  crc6;
  logic        rise;
  logic        tmo;
  logic        warn;
  logic [15:0] tlim;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] crc4_byte(input logic [7:0] d);
    logic [3:0] c;
    logic       fb;
    c = '0;
    for (int i = 7; i >= 0; i--) begin
      fb = d[i] ^ c[3];
      c  = {c[2:0], 1'b0} ^ (fb ? CRC4_POLY[3:0] : 4'h0);
    end
    return c;
  endfunction : crc4_byte

  function automatic logic [63:0] put(input logic [63:0] acc, input logic [63:0] v,
                                      input logic [6:0] w, input logic [6:0] pos);
    return acc | ((v & ~({64{1'b1}} << w)) << (7'd64 - pos - w));
  endfunction : put

  function automatic logic [6:0] align_bits(input logic [4:0] stb);
    case (stb)
      5'd15:   return 7'd2;
      5'd16:   return 7'd1;
      5'd18:   return 7'd6;
      5'd19:   return 7'd5;
      5'd20:   return 7'd4;
      5'd21:   return 7'd3;
      5'd22:   return 7'd2;
      5'd23:   return 7'd1;
      default: return 7'd0;
    endcase
  endfunction : align_bits

  function automatic logic [IW:0] ridx(input logic [7:0] a);
    return {a[7], a[IW-1:0]};
  endfunction : ridx

  ebs_crc_ser #(
    .W    (6),
    .POLY (CRC6_POLY)
  ) u_crc6 (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_clr   (crc_clr),
    .i_en    (crc_en),
    .i_bit   (q.sh[63]),
    .o_crc   (crc6)
  );

  // Only the second sampler stage and its delay are ever looked at
  assign rise = q.ma2 & ~q.mad;
  assign tlim = q.regm ? TOR_CYCLES[15:0] : TOS_CYC[15:0];
  assign tmo  = q.ma2 & q.mad & (q.tmr >= tlim);
  assign warn = q.ctrl[CTRL_VAR] ? (i_temp < WARN_LO_B || i_temp > WARN_HI_B)
                                 : (i_temp < WARN_LO_A || i_temp > WARN_HI_A);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [63:0] acc;
    logic [6:0]  p;
    logic [6:0]  mtb;
    logic [6:0]  stb;
    logic        bit_v;
    logic [7:0]  rdb;
    acc     = '0;
    p       = '0;
    mtb     = {2'b00, q.cfg[CFG_MT +: 5]};
    stb     = {2'b00, q.cfg[CFG_ST +: 5]};
    bit_v   = ({q.hi[14:0], 1'b0} > q.per);
    rdb     = mem[ridx(q.addr8)];
    n       = q;
    we      = 1'b0;
    widx    = '0;
    wd      = '0;
    crc_clr = 1'b0;
    crc_en  = 1'b0;

    n.ma1 = i_ma;
    n.ma2 = q.ma1;
    n.mad = q.ma2;
    n.div = (q.div == 6'(INT_DIV - 1)) ? 6'd0 : q.div + 6'd1;
    n.tmr = (q.ma2 != q.mad) ? 16'd0 : (q.tmr == 16'hFFFF ? q.tmr : q.tmr + 16'd1);
    n.per = q.per + 16'd1;
    n.hi  = q.ma2 ? q.hi + 16'd1 : q.hi;
    n.talarm = (i_temp < q.lim[LIM_LO +: 8]) || (i_temp > q.lim[LIM_HI +: 8]);

    // Conversion: BiSS counts system cycles, SSI counts internal ticks
    if (q.conv != 16'd0) begin
      if (q.ctrl[CTRL_BISS] || q.div == 6'(INT_DIV - 1)) begin
        n.conv = q.conv - 16'd1;
      end
    end

    // Background write into the backed half of the register space
    if (q.nvm != '0) begin
      n.nvm = q.nvm - 1'b1;
      if (q.nvm == CNT_W'(1)) begin
        we   = 1'b1;
        widx = ridx(q.nva);
        wd   = q.nvd;
      end
    end
    if (q.wait_c != '0) begin
      n.wait_c = q.wait_c - 1'b1;
    end

    // Pulse-width sampling restarts on every rising edge
    if (rise) begin
      n.per = 16'd0;
      n.hi  = 16'd0;
      n.got = 1'b1;
    end

    case (q.st)
      EBS_IDLE: begin
        n.slo  = 1'b1;
        n.regm = 1'b0;
        if (!q.ma2 && q.mad) begin
          acc = put(acc, 64'(i_mt_pos), mtb, p);
          p   = p + mtb;
          acc = put(acc, 64'(i_st_pos), stb, p);
          p   = p + stb + align_bits(q.cfg[CFG_ST +: 5]);
          acc = put(acc, 64'(i_led_over), 7'd1, p);
          p   = p + 7'd1;
          acc = put(acc, 64'(warn), 7'd1, p);
          p   = p + 7'd1;
          if (!q.ctrl[CTRL_BISS]) begin
            acc = put(acc, 64'({i_temp, ~crc4_byte(i_temp)}), SSI_EXTRA, p);
            p   = p + SSI_EXTRA;
          end
          n.sh    = acc;
          n.left  = p;
          n.phcrc = 1'b0;
          n.ack   = 1'b0;
          n.got   = 1'b0;
          n.conv  = q.ctrl[CTRL_BISS]
                  ? 16'(CONV_CYC * (q.cfg[CFG_IP +: 3] + 1))
                  : 16'(SAR_TICKS * (q.cfg[CFG_IP +: 3] + 1));
          crc_clr = 1'b1;
          n.st    = EBS_START;
        end
      end

      EBS_START: begin
        if (q.ctrl[CTRL_BISS] && !q.ma2 && q.tmr >= TOS_CYC[15:0]) begin
          n.slo  = 1'b0;
          n.regm = 1'b1;
          n.got  = 1'b0;
          n.bitn = '0;
          n.st   = EBS_REG_RX;
        end else if (rise) begin
          if (q.ctrl[CTRL_BISS]) begin
            n.st = EBS_SENSE;
          end else begin
            // Master is trusted to respect the conversion time here
            n.slo  = q.sh[63];
            n.sh   = {q.sh[62:0], 1'b0};
            n.left = q.left - 7'd1;
            n.st   = EBS_SHIFT;
          end
        end
      end

      EBS_SENSE: begin
        if (tmo) begin
          n.st = EBS_IDLE;
        end else if (rise) begin
          if (!q.ack) begin
            n.slo = 1'b0;
            n.ack = 1'b1;
          end else if (q.conv == 16'd0) begin
            n.slo = 1'b1;
            n.st  = EBS_SHIFT;
          end
        end
      end

      EBS_SHIFT: begin
        if (tmo) begin
          n.st = EBS_IDLE;
        end else if (rise) begin
          if (q.left != 7'd0) begin
            n.slo  = q.sh[63];
            n.sh   = {q.sh[62:0], 1'b0};
            n.left = q.left - 7'd1;
            crc_en = q.ctrl[CTRL_BISS] && !q.phcrc;
          end else if (q.ctrl[CTRL_BISS] && !q.phcrc && !q.regm) begin
            n.slo   = ~crc6[5];
            n.sh    = {~crc6[4:0], 59'd0};
            n.left  = CRC6_BITS - 7'd1;
            n.phcrc = 1'b1;
          end else begin
            n.slo = 1'b0;
            n.st  = EBS_TAIL;
          end
        end
      end

      EBS_REG_RX: begin
        if (tmo) begin
          n.st = EBS_IDLE;
        end else if (rise && q.got) begin
          n.rx   = {q.rx[14:0], bit_v};
          n.bitn = q.bitn + 5'd1;
          if (q.bitn + 5'd1 == RX_BITS) begin
            n.addr8  = {q.rx[11], q.rx[10:4]};
            n.hit    = (q.rx[13:12] == SLAVE_ID[2:1]);
            n.bitn   = '0;
            n.wait_c = q.rx[11] ? CNT_W'(NVM_RD_CYC) : '0;
            n.st     = q.rx[3] ? EBS_REG_WR : EBS_REG_RD;
          end
        end
      end

      EBS_REG_RD: begin
        if (tmo) begin
          n.st = EBS_IDLE;
        end else if (rise) begin
          if (!q.hit) begin
            n.st = EBS_TAIL;
          end else if (q.wait_c == '0) begin
            n.slo   = 1'b1;
            n.sh    = {rdb, ~crc4_byte(rdb), 52'd0};
            n.left  = RD_BITS - 7'd1;
            n.phcrc = 1'b1;
            n.st    = EBS_SHIFT;
          end
        end
      end

      EBS_REG_WR: begin
        if (tmo) begin
          n.st = EBS_IDLE;
        end else if (rise && q.got) begin
          n.slo  = bit_v;
          n.rx   = {q.rx[14:0], bit_v};
          n.bitn = q.bitn + 5'd1;
          if (q.bitn + 5'd1 == WR_BITS) begin
            n.st = EBS_TAIL;
            if (q.hit && {q.rx[2:0], bit_v} == ~crc4_byte(q.rx[10:3])) begin
              if (q.addr8[7]) begin
                if (q.nvm == '0) begin
                  n.nvm = CNT_W'(NVM_WR_CYC);
                  n.nva = q.addr8;
                  n.nvd = q.rx[10:3];
                end
              end else begin
                we   = 1'b1;
                widx = ridx(q.addr8);
                wd   = q.rx[10:3];
              end
            end
          end
        end
      end

      EBS_TAIL: begin
        if (rise) begin
          n.slo = 1'b0;
        end
        if (tmo) begin
          n.slo = 1'b1;
          n.st  = EBS_IDLE;
        end
      end

      default: begin
        n.st = EBS_IDLE;
      end
    endcase

    // Timeout in mid-frame returns the line high at once
    if (tmo && q.st != EBS_IDLE && q.st != EBS_TAIL) begin
      n.slo = 1'b1;
    end

    // Software port; read data stands for one cycle only
    if (i_wr) begin
      if (i_addr == REG_CTRL) begin
        n.ctrl = i_wdata;
      end else if (i_addr == REG_CFG) begin
        n.cfg = i_wdata;
      end else if (i_addr == REG_LIM) begin
        n.lim = i_wdata;
      end
    end
    n.rdata = '0;
    if (i_rd) begin
      if (i_addr == REG_CTRL) begin
        n.rdata = q.ctrl;
      end else if (i_addr == REG_CFG) begin
        n.rdata = q.cfg;
      end else if (i_addr == REG_LIM) begin
        n.rdata = q.lim;
      end else if (i_addr == REG_STAT) begin
        n.rdata = {25'd0, q.nvm != '0, q.regm, q.st != EBS_IDLE,
                   q.conv == 16'd0, warn, i_led_over, q.talarm};
      end else if (i_addr == REG_TEMP) begin
        n.rdata = {24'd0, i_temp};
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q      <= '0;
      q.st   <= EBS_IDLE;
      q.slo  <= 1'b1;
      q.ma1  <= 1'b1;
      q.ma2  <= 1'b1;
      q.mad  <= 1'b1;
      q.ctrl <= CTRL_RST;
      q.cfg  <= CFG_RST;
      q.lim  <= LIM_RST;
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (we) begin
      mem[widx] <= wd;
    end
  end

  assign o_slo        = q.slo;
  assign o_rdata      = q.rdata;
  assign o_temp_alarm = q.talarm;
endmodule : ebs_slave

// [bench/ebs_slave_props.sv]
`timescale 1ns/1ps
module ebs_slave_props #(
  parameter int TOR_CYCLES = ebs_pkg::TOR_CYC
) (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_ma,
  input wire logic        o_slo,
  input wire logic [7:0]  i_temp,
  input wire logic        i_led_over,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_temp_alarm
);
  import ebs_pkg::*;
  // ----------------
  // Link tracking and shadows
  // ----------------
  logic [1:0]  ma_r;
  logic [15:0] hi_cnt_r;
  logic [15:0] lo_cnt_r;
  logic [1:0]  rise_cnt_r;
  logic        idle_r;
  logic        bis_r;
  logic [7:0]  lim_lo_r;
  logic [7:0]  lim_hi_r;
  logic        ma_rise;
  logic        ma_fall;
  assign ma_rise = ma_r[0] && !ma_r[1];
  assign ma_fall = !ma_r[0] && ma_r[1];
  // Saturating, so a parked line never wraps into a false timeout
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ma_r       <= 2'b11;
      hi_cnt_r   <= 16'h0000;
      lo_cnt_r   <= 16'h0000;
      rise_cnt_r <= 2'd3;
      idle_r     <= 1'b1;
      bis_r      <= CTRL_RST[CTRL_BISS];
      lim_lo_r   <= LIM_RST[LIM_LO +: 8];
      lim_hi_r   <= LIM_RST[LIM_HI +: 8];
    end else begin
      ma_r     <= {ma_r[0], i_ma};
      hi_cnt_r <= ma_r[0] ? hi_cnt_r + 16'(hi_cnt_r != 16'hFFFF) : 16'h0000;
      lo_cnt_r <= ma_r[0] ? 16'h0000 : lo_cnt_r + 16'(lo_cnt_r != 16'hFFFF);
      if (ma_fall) begin
        idle_r <= 1'b0;
      end else if (int'(hi_cnt_r) >= TOS_CYC) begin
        idle_r <= 1'b1;
      end
      if (ma_fall && idle_r) begin
        rise_cnt_r <= 2'd0;
      end else if (ma_rise && rise_cnt_r != 2'd3) begin
        rise_cnt_r <= rise_cnt_r + 2'd1;
      end
      if (i_wr && i_addr == REG_CTRL) begin
        bis_r <= i_wdata[CTRL_BISS];
      end
      if (i_wr && i_addr == REG_LIM) begin
        lim_lo_r <= i_wdata[LIM_LO +: 8];
        lim_hi_r <= i_wdata[LIM_HI +: 8];
      end
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence second_rise_s;
    bis_r && ma_rise && rise_cnt_r == 2'd1;
  endsequence
  sequence ack_seen_s;
    ##[0:8] !o_slo;
  endsequence
  sequence long_low_s;
    bis_r && int'(lo_cnt_r) == TOS_CYC + 16;
  endsequence
  ack_low_a: assert property (second_rise_s |-> ack_seen_s)
    else $error("no acknowledge low on second rise");
  reg_entry_a: assert property (long_low_s |-> !o_slo)
    else $error("long low did not pull data line down");
  idle_high_a: assert property (int'(hi_cnt_r) == TOR_CYCLES + 16 |-> o_slo)
    else $error("data line not idle after timeout");
  alarm_on_a: assert property ((i_temp < lim_lo_r || i_temp > lim_hi_r) |=> o_temp_alarm)
    else $error("alarm missing outside limits");
  alarm_off_a: assert property ((i_temp >= lim_lo_r && i_temp <= lim_hi_r) |=> !o_temp_alarm)
    else $error("alarm set inside limits");
  temp_read_a: assert property (i_rd && i_addr == REG_TEMP && $stable(i_temp)
    |=> o_rdata == {24'h00_0000, $past(i_temp)})
    else $error("temperature read mismatch");
  stat_bits_a: assert property (i_rd && i_addr == REG_STAT && $stable(i_led_over)
    && $stable(o_temp_alarm) |=> o_rdata[1:0] == {$past(i_led_over), $past(o_temp_alarm)})
    else $error("status bits mismatch");
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not cleared");
endmodule : ebs_slave_props

// [bench/ebs_master_model.sv]
`timescale 1ns/1ps
module ebs_master_model (
  input  wire logic i_slo,
  output logic      o_ma
);
  // ----------------
  // Master clock line
  // ----------------
  // Line stands high between frames
  initial o_ma = 1'b1;
  // Offset keeps master edges off the system clock edge
  task automatic frame(input int n, input realtime low0, input realtime half,
                       output logic [127:0] b);
    b = '0;
    #1.3;
    o_ma = 1'b0;
    #(low0);
    for (int k = 0; k < n; k++) begin
      o_ma = 1'b1;
      #(half);
      b[k] = i_slo;
      o_ma = 1'b0;
      #(half);
    end
    o_ma = 1'b1;
  endtask : frame
  // Duty-cycle coded bits, high 3/4 for a one, 1/4 for a zero
  task automatic pwm(input int n, input logic [127:0] v, input realtime p,
                     output logic [127:0] b);
    b = '0;
    for (int k = 0; k < n; k++) begin
      o_ma = 1'b1;
      #(v[k] ? 3.0 * p : p);
      b[k] = i_slo;
      o_ma = 1'b0;
      #(v[k] ? p : 3.0 * p);
    end
    o_ma = 1'b1;
  endtask : pwm
  task automatic hold_low(input realtime t, output logic b);
    #1.3;
    o_ma = 1'b0;
    #(t);
    b = i_slo;
    o_ma = 1'b1;
  endtask : hold_low
endmodule : ebs_master_model

// [bench/ebs_slave_bench.sv]
`timescale 1ns/1ps
module ebs_slave_bench;
  import ebs_pkg::*;
  localparam int TOR_T = 4000;
  logic         i_clk;
  logic         i_rst_b;
  logic         i_ma;
  logic         o_slo;
  logic [23:0]  i_st_pos;
  logic [23:0]  i_mt_pos;
  logic [7:0]   i_temp;
  logic         i_led_over;
  logic [7:0]   i_addr;
  logic [31:0]  i_wdata;
  logic         i_wr;
  logic         i_rd;
  logic [31:0]  o_rdata;
  logic         o_temp_alarm;
  logic [127:0] bits;
  logic         q[$];
  int           err_count;
  int           total_checks;
  // Short register timeout and memory delays keep the run brief
  ebs_slave #(.TOR_CYCLES(TOR_T), .NVM_RD_CYC(50), .NVM_WR_CYC(20)) DUT (
    .i_clk, .i_rst_b, .i_ma, .o_slo, .i_st_pos, .i_mt_pos, .i_temp, .i_led_over,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_temp_alarm
  );
  ebs_master_model u_mst (.i_slo(o_slo), .o_ma(i_ma));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    #300us;
    err_count++;
    finish_test();
  end
  // ----------------
  // Shared helpers
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata & m, e);
  endtask : rdc
  task automatic push(input logic [23:0] v, input int w);
    for (int i = w - 1; i >= 0; i--) q.push_back(v[i]);
  endtask : push
  function automatic logic [5:0] crc(input int from, input int w, input logic [6:0] p);
    logic [5:0] c;
    logic       fb;
    c = 6'h00;
    for (int i = from; i < q.size(); i++) begin
      fb = c[w-1] ^ q[i];
      c  = c << 1;
      if (fb) c = c ^ p[5:0];
    end
    return c & 6'((1 << w) - 1);
  endfunction : crc
  task automatic cmp_frame(input int off);
    for (int i = 0; i < q.size(); i++) chk({31'h0, bits[off+i]}, {31'h0, q[i]});
  endtask : cmp_frame
  task automatic wait_idle;
    int i;
    repeat (TOS_CYC - 100) @(posedge i_clk);
    chk({31'h0, o_slo}, 32'h0000_0000);
    i = 0;
    while (o_slo !== 1'b1 && i < TOR_T) begin
      @(posedge i_clk);
      i++;
    end
    chk({31'h0, o_slo}, 32'h0000_0001);
  endtask : wait_idle
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_regs;
    rdc(REG_CTRL, CTRL_RST);
    rdc(REG_CFG, CFG_RST);
    rdc(REG_LIM, LIM_RST);
    wr(8'h14, 32'hFFFF_FFFF);
    rdc(8'h14, 32'h0000_0000);
    rdc(REG_TEMP, {24'h00_0000, TEMP_ZERO});
  endtask : t_regs
  task automatic t_alarm;
    logic a;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0 || i == 3);
      i_temp <= (i < 2) ? LIM_RST[7:0] - 8'h01 + 8'(i) : LIM_RST[15:8] + 8'(i - 2);
      repeat (3) @(posedge i_clk);
      #1;
      chk({31'h0, o_temp_alarm}, {31'h0, a});
      rdc(REG_STAT, {29'h0, 2'b10, a}, 32'h0000_0007);
    end
    i_temp <= WARN_LO_B - 8'h01;
    wr(REG_CTRL, 32'h0000_0002);
    rdc(REG_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(REG_CTRL, CTRL_RST);
    rdc(REG_STAT, 32'h0000_0000, 32'h0000_0004);
  endtask : t_alarm
  task automatic t_ssi;
    int         t0;
    logic [5:0] c;
    i_mt_pos <= 24'h00_0ABC;
    i_st_pos <= 24'h00_1A5A;
    i_temp   <= 8'h59;
    q.delete();
    push(24'h00_0ABC, 12);
    push(24'h00_1A5A, 13);
    push(24'h00_0000, 2);
    t0 = q.size();
    push(24'h00_0059, 8);
    c = crc(t0, 4, CRC4_POLY);
    push({20'h0_0000, ~c[3:0]}, 4);
    push(24'h00_0000, 1);
    u_mst.frame(q.size(), 700.0, 125.0, bits);
    cmp_frame(0);
    wait_idle();
  endtask : t_ssi
  task automatic t_biss;
    int         s;
    int         ks;
    logic [5:0] c;
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_CFG, 32'h0002_0C0F);
    i_mt_pos   <= 24'h00_0123;
    i_st_pos   <= 24'h00_5A5A;
    i_temp     <= 8'hB0;
    i_led_over <= 1'b1;
    q.delete();
    push(24'h00_0123, 12);
    push(24'h00_5A5A, 15);
    push(24'h00_0000, 2);
    push(24'h00_0003, 2);
    c = crc(0, 6, CRC6_POLY);
    push({18'h0_0000, ~c}, 6);
    push(24'h00_0000, 1);
    u_mst.frame(100, 24.0, 24.0, bits);
    chk({30'h0, bits[1:0]}, 32'h0000_0001);
    s = 2;
    while (s < 99 && bits[s] !== 1'b1) s++;
    ks = (CONV_CYC * (2 + 1) * 4 - 24) / 48;
    chk(32'(s >= ks && s <= ks + 2), 32'h0000_0001);
    cmp_frame(s + 1);
    i_led_over <= 1'b0;
    wait_idle();
  endtask : t_biss
  task automatic t_regmode;
    logic b;
    u_mst.hold_low(13000.0, b);
    chk({31'h0, b}, 32'h0000_0000);
    wait_idle();
  endtask : t_regmode
  // Write an internal byte, then read it back with its check bits
  task automatic t_regrw;
    logic         b;
    logic [5:0]   c;
    logic [12:0]  e;
    logic [29:0]  w;
    logic [127:0] v;
    q.delete();
    push(24'h00_00A5, 8);
    c = crc(0, 4, CRC4_POLY);
    e = {1'b1, 8'hA5, ~c[3:0]};
    for (int r = 0; r < 2; r++) begin
      w = (r == 0) ? {16'h80B0, e, 1'b0} : {16'h80A0, 14'h3FFF};
      v = '0;
      for (int k = 0; k < 30; k++) v[k] = w[29-k];
      u_mst.hold_low(13000.0, b);
      chk({31'h0, b}, 32'h0000_0000);
      u_mst.pwm(30, v, 48.0, bits);
      for (int j = 0; j < 13; j++) chk({31'h0, bits[17+j]}, {31'h0, e[12-j]});
      wait_idle();
    end
  endtask : t_regrw
  task automatic t_rerst;
    i_rst_b <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    rdc(REG_CTRL, CTRL_RST);
    rdc(REG_CFG, CFG_RST);
  endtask : t_rerst
  task automatic finish_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    i_rst_b    = 1'b0;
    i_st_pos   = 24'h00_0000;
    i_mt_pos   = 24'h00_0000;
    i_temp     = TEMP_ZERO;
    i_led_over = 1'b0;
    i_addr     = 8'h00;
    i_wdata    = 32'h0000_0000;
    i_wr       = 1'b0;
    i_rd       = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_regs();
    t_alarm();
    t_ssi();
    t_biss();
    t_regmode();
    t_regrw();
    t_rerst();
    finish_test();
  end
endmodule : ebs_slave_bench
bind ebs_slave ebs_slave_props #(.TOR_CYCLES(TOR_CYCLES)) u_props (
  .i_clk, .i_rst_b, .i_ma, .o_slo, .i_temp, .i_led_over, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .o_temp_alarm
);
